// file: src/cca_access.sv
// Register access for the 16-bit counter array: counter bytes, snapshot and module bytes
//
// Overview of operation
// - The counter low byte is a read/write register at 0xf9 that resets to zero.
// - Writes to the counter low byte are ignored while the watchdog enable bit is set.
// - Reading the counter high byte at 0xfa returns a snapshot refreshed only when the low byte is read.
// - Writes to the counter high byte are blocked while the watchdog enable bit is set.
// - Each module low-byte address reaches the compare low byte or the reload low byte per the reload select bit.
// - Writing a module low byte clears that module's compare function enable.
// - Each module high-byte address reaches the compare high byte or the reload high byte per the reload select bit.
// - Writing a module high byte sets that module's compare function enable.
// - A module with compare function enable set compares its value against the running counter.
// - While the watchdog enable bit is set, module 2 acts as watchdog and its mode register is write-protected.
`timescale 1ns/1ps
module cca_access
  import cca_pkg::*;
#(
  parameter int unsigned NUM_MODULES = CCA_NUM_MODULES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic watchdog_enable_bit_i,
  input wire logic reload_select_bit_i,
  input wire logic count_tick_i,
  input wire logic [NUM_MODULES-1:0] mode_ecom_wr_i,
  input wire logic [NUM_MODULES-1:0] mode_ecom_val_i,
  output logic [7:0] sfr_rdata_o,
  output logic [15:0] counter_o,
  output logic [NUM_MODULES*16-1:0] compare_value_o,
  output logic [NUM_MODULES*16-1:0] reload_value_o,
  output logic [NUM_MODULES-1:0] compare_function_enable_o,
  output logic [NUM_MODULES-1:0] match_o,
  output logic watchdog_module_o
);
  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic [7:0] lo_addr(input int unsigned m);
    case (m)
      0: lo_addr = CCA_ADDR_M0_LO;
      1: lo_addr = CCA_ADDR_M1_LO;
      default: lo_addr = CCA_ADDR_M2_LO;
    endcase
  endfunction : lo_addr

  function automatic logic [7:0] hi_addr(input int unsigned m);
    case (m)
      0: hi_addr = CCA_ADDR_M0_HI;
      1: hi_addr = CCA_ADDR_M1_HI;
      default: hi_addr = CCA_ADDR_M2_HI;
    endcase
  endfunction : hi_addr

  logic [15:0] cnt_q, cnt_d;
  logic [7:0] snap_q, snap_d;
  logic [7:0] rdata_q, rdata_d;
  logic wdog_q, wdog_d;
  logic wr_cnt_lo, wr_cnt_hi, rd_cnt_lo;
  logic [NUM_MODULES-1:0] wr_lo, wr_hi, rd_lo_sel, rd_hi_sel, ecom_wr;
  logic [7:0] ch_rd_lo [NUM_MODULES];
  logic [7:0] ch_rd_hi [NUM_MODULES];
  logic [15:0] ch_cmp [NUM_MODULES];
  logic [15:0] ch_rld [NUM_MODULES];

  assign wr_cnt_lo = sfr_wr_i && (sfr_addr_i == CCA_ADDR_CNT_LO);
  assign wr_cnt_hi = sfr_wr_i && (sfr_addr_i == CCA_ADDR_CNT_HI);
  assign rd_cnt_lo = sfr_rd_i && (sfr_addr_i == CCA_ADDR_CNT_LO);

  // ****************************************************************
  // Capture/compare modules
  // ****************************************************************
  for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
    assign wr_lo[m] = sfr_wr_i && (sfr_addr_i == lo_addr(m));
    assign wr_hi[m] = sfr_wr_i && (sfr_addr_i == hi_addr(m));
    assign rd_lo_sel[m] = sfr_addr_i == lo_addr(m);
    assign rd_hi_sel[m] = sfr_addr_i == hi_addr(m);
    // Watchdog owns module 2's mode while enabled
    if (m == CCA_WDOG_MODULE) begin : g_wd
      assign ecom_wr[m] = mode_ecom_wr_i[m] && !watchdog_enable_bit_i;
    end else begin : g_nwd
      assign ecom_wr[m] = mode_ecom_wr_i[m];
    end
    cca_channel u_chan (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .wr_lo_i(wr_lo[m]),
      .wr_hi_i(wr_hi[m]),
      .wdata_i(sfr_wdata_i),
      .reload_select_bit_i(reload_select_bit_i),
      .mode_ecom_wr_i(ecom_wr[m]),
      .mode_ecom_val_i(mode_ecom_val_i[m]),
      .count_i(cnt_q),
      .rd_lo_o(ch_rd_lo[m]),
      .rd_hi_o(ch_rd_hi[m]),
      .compare_o(ch_cmp[m]),
      .reload_o(ch_rld[m]),
      .ecom_o(compare_function_enable_o[m]),
      .match_o(match_o[m])
    );
    assign compare_value_o[m*16 +: 16] = ch_cmp[m];
    assign reload_value_o[m*16 +: 16] = ch_rld[m];
  end

  // ****************************************************************
  // Counter, snapshot and read data
  // ****************************************************************
  always_comb begin
    cnt_d = cnt_q;
    snap_d = snap_q;
    rdata_d = rdata_q;
    wdog_d = watchdog_enable_bit_i;
    // A software write to a counter byte wins over a count tick in the same cycle for that byte only; the other byte takes the ticked value
    if (count_tick_i) begin
      cnt_d = cnt_q + 16'h0001;
    end
    if (wr_cnt_lo && !watchdog_enable_bit_i) begin
      cnt_d[CCA_BYTE_LO +: 8] = sfr_wdata_i;
    end
    if (wr_cnt_hi && !watchdog_enable_bit_i) begin
      cnt_d[CCA_BYTE_HI +: 8] = sfr_wdata_i;
    end
    if (rd_cnt_lo) begin
      snap_d = cnt_q[CCA_BYTE_HI +: 8];
    end
    if (sfr_rd_i) begin
      rdata_d = CCA_UNMAPPED_RD;
      if (sfr_addr_i == CCA_ADDR_CNT_LO) begin
        rdata_d = cnt_q[CCA_BYTE_LO +: 8];
      end else if (sfr_addr_i == CCA_ADDR_CNT_HI) begin
        rdata_d = snap_q;
      end
      for (int m = 0; m < NUM_MODULES; m++) begin
        if (rd_lo_sel[m]) begin
          rdata_d = ch_rd_lo[m];
        end
        if (rd_hi_sel[m]) begin
          rdata_d = ch_rd_hi[m];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= CCA_WORD_RST;
      snap_q <= CCA_BYTE_RST;
      rdata_q <= CCA_BYTE_RST;
      wdog_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      snap_q <= snap_d;
      rdata_q <= rdata_d;
      wdog_q <= wdog_d;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign counter_o = cnt_q;
  assign watchdog_module_o = wdog_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_lo_write0;
    sfr_wr_i && sfr_addr_i == CCA_ADDR_M0_LO;
  endsequence
  sequence s_hi_write0;
    sfr_wr_i && sfr_addr_i == CCA_ADDR_M0_HI;
  endsequence

  property p_cnt_lo_write;
    @(posedge clk_i) disable iff (!rst_n_i)
      wr_cnt_lo && !watchdog_enable_bit_i |=> cnt_q[7:0] == $past(sfr_wdata_i);
  endproperty
  a_cnt_lo_write: assert property (p_cnt_lo_write) else $error("counter low byte write lost");

  property p_cnt_lo_locked;
    @(posedge clk_i) disable iff (!rst_n_i)
      wr_cnt_lo && watchdog_enable_bit_i && !count_tick_i |=> $stable(cnt_q);
  endproperty
  a_cnt_lo_locked: assert property (p_cnt_lo_locked) else $error("counter low byte changed under watchdog");

  property p_snapshot;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_cnt_lo ##1 (sfr_rd_i && sfr_addr_i == CCA_ADDR_CNT_HI) |=> sfr_rdata_o == $past(cnt_q[15:8], 2);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("high byte read did not return snapshot");

  property p_cnt_hi_locked;
    @(posedge clk_i) disable iff (!rst_n_i)
      wr_cnt_hi && watchdog_enable_bit_i && !count_tick_i |=> $stable(cnt_q);
  endproperty
  a_cnt_hi_locked: assert property (p_cnt_hi_locked) else $error("counter high byte changed under watchdog");

  property p_lo_routing;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_lo_write0 ##0 !reload_select_bit_i |=> ch_cmp[0][7:0] == $past(sfr_wdata_i) && $stable(ch_rld[0]);
  endproperty
  a_lo_routing: assert property (p_lo_routing) else $error("module low write misrouted");

  property p_lo_clears_ecom;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_lo_write0 |=> !compare_function_enable_o[0];
  endproperty
  a_lo_clears_ecom: assert property (p_lo_clears_ecom) else $error("low write did not clear enable");

  property p_hi_routing;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_hi_write0 ##0 reload_select_bit_i |=> ch_rld[0][15:8] == $past(sfr_wdata_i) && $stable(ch_cmp[0]);
  endproperty
  a_hi_routing: assert property (p_hi_routing) else $error("module high write misrouted");

  property p_hi_sets_ecom;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_hi_write0 |=> compare_function_enable_o[0];
  endproperty
  a_hi_sets_ecom: assert property (p_hi_sets_ecom) else $error("high write did not set enable");

  property p_match;
    @(posedge clk_i) disable iff (!rst_n_i)
      compare_function_enable_o[0] && cnt_q == ch_cmp[0] |=> match_o[0];
  endproperty
  a_match: assert property (p_match) else $error("enabled compare missed a match");

  property p_wdog_mode_lock;
    @(posedge clk_i) disable iff (!rst_n_i)
      watchdog_enable_bit_i && !wr_lo[2] && !wr_hi[2] |=> $stable(compare_function_enable_o[2]);
  endproperty
  a_wdog_mode_lock: assert property (p_wdog_mode_lock) else $error("module 2 mode changed under watchdog");

  property p_reload_read;
    @(posedge clk_i) disable iff (!rst_n_i)
      sfr_rd_i && sfr_addr_i == CCA_ADDR_M1_LO && reload_select_bit_i |=> sfr_rdata_o == $past(ch_rld[1][7:0]);
  endproperty
  a_reload_read: assert property (p_reload_read) else $error("module read ignored reload select");
endmodule : cca_access

// file: src/cca_pkg.sv
// Package: addresses, reset values and sizes of the counter-array access block
package cca_pkg;
  localparam int unsigned CCA_NUM_MODULES = 3;
  localparam int unsigned CCA_CNT_W = 16;
  localparam logic [7:0] CCA_ADDR_CNT_LO = 8'hf9;
  localparam logic [7:0] CCA_ADDR_CNT_HI = 8'hfa;
  localparam logic [7:0] CCA_ADDR_M0_LO = 8'hfb;
  localparam logic [7:0] CCA_ADDR_M0_HI = 8'hfc;
  localparam logic [7:0] CCA_ADDR_M1_LO = 8'he9;
  localparam logic [7:0] CCA_ADDR_M1_HI = 8'hea;
  localparam logic [7:0] CCA_ADDR_M2_LO = 8'heb;
  localparam logic [7:0] CCA_ADDR_M2_HI = 8'hec;
  localparam logic [7:0] CCA_BYTE_RST = 8'h00;
  localparam logic [15:0] CCA_WORD_RST = 16'h0000;
  localparam logic [7:0] CCA_UNMAPPED_RD = 8'h00;
  localparam int unsigned CCA_WDOG_MODULE = 2;
  localparam int unsigned CCA_BYTE_LO = 0;
  localparam int unsigned CCA_BYTE_HI = 8;
endpackage : cca_pkg

// file: src/cca_channel.sv
// One capture/compare module: compare value, auto-reload value and compare enable
`timescale 1ns/1ps
module cca_channel
  import cca_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [7:0] wdata_i,
  input wire logic reload_select_bit_i,
  input wire logic mode_ecom_wr_i,
  input wire logic mode_ecom_val_i,
  input wire logic [15:0] count_i,
  output logic [7:0] rd_lo_o,
  output logic [7:0] rd_hi_o,
  output logic [15:0] compare_o,
  output logic [15:0] reload_o,
  output logic ecom_o,
  output logic match_o
);
  logic [15:0] cmp_q, cmp_d, rld_q, rld_d;
  logic ecom_q, ecom_d, match_q, match_d;

  always_comb begin
    cmp_d = cmp_q;
    rld_d = rld_q;
    ecom_d = ecom_q;
    if (wr_lo_i) begin
      if (reload_select_bit_i) begin
        rld_d[CCA_BYTE_LO +: 8] = wdata_i;
      end else begin
        cmp_d[CCA_BYTE_LO +: 8] = wdata_i;
      end
      ecom_d = 1'b0;
    end else if (wr_hi_i) begin
      if (reload_select_bit_i) begin
        rld_d[CCA_BYTE_HI +: 8] = wdata_i;
      end else begin
        cmp_d[CCA_BYTE_HI +: 8] = wdata_i;
      end
      ecom_d = 1'b1;
    end else if (mode_ecom_wr_i) begin
      ecom_d = mode_ecom_val_i;
    end
    // Comparator only runs while enabled
    match_d = ecom_q && (count_i == cmp_q);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_q <= CCA_WORD_RST;
      rld_q <= CCA_WORD_RST;
      ecom_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      cmp_q <= cmp_d;
      rld_q <= rld_d;
      ecom_q <= ecom_d;
      match_q <= match_d;
    end
  end

  // Readback follows the current select, even mid-sequence
  assign rd_lo_o = reload_select_bit_i ? rld_q[CCA_BYTE_LO +: 8] : cmp_q[CCA_BYTE_LO +: 8];
  assign rd_hi_o = reload_select_bit_i ? rld_q[CCA_BYTE_HI +: 8] : cmp_q[CCA_BYTE_HI +: 8];
  assign compare_o = cmp_q;
  assign reload_o = rld_q;
  assign ecom_o = ecom_q;
  assign match_o = match_q;
endmodule : cca_channel

// file: tb/cca_access_tb.sv
// Self-checking testbench for the counter-array register access block
`timescale 1ns/1ps
module cca_access_tb;
  import cca_pkg::*;
  logic clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, wd_i, sel_i, tick_i, wdm_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [2:0] ecwr_i, ecval_i, cfe_o, match_o;
  logic [15:0] counter_o;
  logic [47:0] cmp_o, rld_o;
  logic [7:0] lo_a [3] = '{CCA_ADDR_M0_LO, CCA_ADDR_M1_LO, CCA_ADDR_M2_LO};
  logic [7:0] hi_a [3] = '{CCA_ADDR_M0_HI, CCA_ADDR_M1_HI, CCA_ADDR_M2_HI};
  int miscompares;
  int tests_run;

  cca_access #(.NUM_MODULES(3)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .watchdog_enable_bit_i(wd_i),
    .reload_select_bit_i(sel_i), .count_tick_i(tick_i), .mode_ecom_wr_i(ecwr_i), .mode_ecom_val_i(ecval_i),
    .sfr_rdata_o(sfr_rdata_o), .counter_o(counter_o), .compare_value_o(cmp_o), .reload_value_o(rld_o),
    .compare_function_enable_o(cfe_o), .match_o(match_o), .watchdog_module_o(wdm_o));

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge clk_i);
    #1;
    sfr_wr_i = 1'b0;
  endtask : wr

  // Read data is registered, so it is judged just after the edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    #1;
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    sfr_rd_i = 1'b0;
    chk({8'h00, sfr_rdata_o}, {8'h00, e});
  endtask : rd

  // Low then high read on consecutive edges: the high read must see the copy taken one edge earlier
  task automatic rd_pair(input logic [7:0] e_lo, input logic [7:0] e_hi);
    @(posedge clk_i);
    #1;
    sfr_addr_i = CCA_ADDR_CNT_LO;
    sfr_rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    chk({8'h00, sfr_rdata_o}, {8'h00, e_lo});
    sfr_addr_i = CCA_ADDR_CNT_HI;
    @(posedge clk_i);
    #1;
    sfr_rd_i = 1'b0;
    chk({8'h00, sfr_rdata_o}, {8'h00, e_hi});
  endtask : rd_pair

  task automatic pulse(input logic tick, input logic [2:0] ew, input logic [2:0] ev);
    @(posedge clk_i);
    #1;
    tick_i = tick;
    ecwr_i = ew;
    ecval_i = ev;
    @(posedge clk_i);
    #1;
    tick_i = 1'b0;
    ecwr_i = 3'h0;
  endtask : pulse

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    for (int m = 0; m < 3; m++) begin
      rd(lo_a[m], CCA_BYTE_RST);
      rd(hi_a[m], CCA_BYTE_RST);
      chk(rld_o[16*m +: 16], CCA_WORD_RST);
      chk(cmp_o[16*m +: 16], CCA_WORD_RST);
    end
    rd(CCA_ADDR_CNT_LO, CCA_BYTE_RST);
    rd(CCA_ADDR_CNT_HI, CCA_BYTE_RST);
    rd(8'h01, CCA_UNMAPPED_RD);
    chk({13'h0, cfe_o}, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_counter();
    wr(CCA_ADDR_CNT_LO, 8'h34);
    wr(CCA_ADDR_CNT_HI, 8'h12);
    chk(counter_o, 16'h1234);
    rd(CCA_ADDR_CNT_LO, 8'h34);
    rd(CCA_ADDR_CNT_HI, 8'h12);
    wd_i = 1'b1;
    wr(CCA_ADDR_CNT_LO, 8'h55);
    wr(CCA_ADDR_CNT_HI, 8'h66);
    chk(counter_o, 16'h1234);
    wd_i = 1'b0;
    $display("test counter done");
  endtask : t_counter

  // Snapshot must hold the old high byte until the low byte is read again
  task automatic t_snapshot();
    wr(CCA_ADDR_CNT_LO, 8'hff);
    wr(CCA_ADDR_CNT_HI, 8'h56);
    rd(CCA_ADDR_CNT_HI, 8'h12);
    pulse(1'b1, 3'h0, 3'h0);
    chk(counter_o, 16'h5700);
    rd(CCA_ADDR_CNT_LO, 8'h00);
    rd(CCA_ADDR_CNT_HI, 8'h57);
    wr(CCA_ADDR_CNT_HI, 8'h9a);
    rd_pair(8'h00, 8'h9a);
    wr(CCA_ADDR_CNT_HI, 8'h57);
    chk(counter_o, 16'h5700);
    $display("test snapshot done");
  endtask : t_snapshot

  task automatic t_modules();
    for (int m = 0; m < 3; m++) begin
      sel_i = 1'b0;
      wr(hi_a[m], 8'h10 + 8'(m));
      chk({15'h0, cfe_o[m]}, 16'h0001);
      wr(lo_a[m], 8'h20 + 8'(m));
      chk({15'h0, cfe_o[m]}, 16'h0000);
      chk(cmp_o[16*m +: 16], {8'h10 + 8'(m), 8'h20 + 8'(m)});
      sel_i = 1'b1;
      wr(lo_a[m], 8'h30 + 8'(m));
      wr(hi_a[m], 8'h40 + 8'(m));
      chk(rld_o[16*m +: 16], {8'h40 + 8'(m), 8'h30 + 8'(m)});
      chk(cmp_o[16*m +: 16], {8'h10 + 8'(m), 8'h20 + 8'(m)});
      rd(lo_a[m], 8'h30 + 8'(m));
      sel_i = 1'b0;
      rd(hi_a[m], 8'h10 + 8'(m));
      rd(lo_a[m], 8'h20 + 8'(m));
    end
    $display("test modules done");
  endtask : t_modules

  task automatic t_match();
    wr(CCA_ADDR_M0_LO, 8'h00);
    wr(CCA_ADDR_M0_HI, 8'h57);
    @(posedge clk_i);
    #1;
    chk({13'h0, match_o}, 16'h0001);
    pulse(1'b0, 3'h1, 3'h0);
    chk({15'h0, cfe_o[0]}, 16'h0000);
    @(posedge clk_i);
    #1;
    chk({15'h0, match_o[0]}, 16'h0000);
    $display("test match done");
  endtask : t_match

  // Module 2 enable is locked while the watchdog owns it
  task automatic t_wdog();
    wd_i = 1'b1;
    @(posedge clk_i);
    #1;
    chk({15'h0, wdm_o}, 16'h0001);
    pulse(1'b0, 3'h6, 3'h0);
    chk({13'h0, cfe_o}, 16'h0004);
    wd_i = 1'b0;
    pulse(1'b0, 3'h4, 3'h0);
    chk({15'h0, cfe_o[2]}, 16'h0000);
    pulse(1'b0, 3'h4, 3'h4);
    chk({15'h0, cfe_o[2]}, 16'h0001);
    chk({15'h0, wdm_o}, 16'h0000);
    $display("test watchdog done");
  endtask : t_wdog

  // ****************
  // Clock, reset and sequence
  // ****************
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end

  initial begin
    miscompares = 0;
    tests_run = 0;
    rst_n_i = 1'b0;
    {sfr_wr_i, sfr_rd_i, wd_i, sel_i, tick_i} = 5'h00;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    ecwr_i = 3'h0;
    ecval_i = 3'h0;
    repeat (16) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_counter();
    t_snapshot();
    t_modules();
    t_match();
    t_wdog();
    complete_run();
  end
endmodule : cca_access_tb
